/* File: srac_cal.sv */
`timescale 1ns/100ps
`include "srac_map.svh"
module srac_cal import srac_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic cal_ack_i,
  output logic busy_o,
  output logic run_o,
  output logic done_o
);
  srac_cal_state_t state;
  srac_cal_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      CAL_IDLE: begin
        if (start_i) next_state = CAL_RUN;
      end
      CAL_RUN: begin
        if (cal_ack_i) next_state = CAL_DONE;
      end
      CAL_DONE: next_state = CAL_IDLE;
      default: next_state = CAL_IDLE;
    endcase
  end

  // busy covers the done cycle too, so a command cannot slip in before done is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= CAL_IDLE;
      busy_o <= 1'b0;
      run_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      state <= next_state;
      busy_o <= (next_state != CAL_IDLE);
      run_o <= (next_state == CAL_RUN);
      done_o <= (next_state == CAL_DONE);
    end
  end

  chk_cal_start_run: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    (state == CAL_IDLE && start_i) |=> (run_o && busy_o))
    else $error("calibration did not start");
  chk_cal_hold_busy: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    (run_o && !cal_ack_i) |=> (run_o && busy_o))
    else $error("calibration ended without acknowledge");
  cov_cal_done: cover property (@(posedge clk_i) disable iff (rst_i) done_o);
endmodule : srac_cal

/* File: srac_cal_eng.sv */
`timescale 1ns/100ps
// ----------------------------------------
// calibration engine model: finishes a fixed
// number of cycles after the run request rises
// ----------------------------------------
module srac_cal_eng import srac_pkg::*; #(
  parameter int ACK_DELAY = 60
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic cal_ack_o
);
  logic [15:0] cnt;
  // ack is a single pulse; after it the model waits for run to drop
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt <= 16'h0000;
      cal_ack_o <= 1'b0;
    end else begin
      cnt <= cnt + 16'h0001;
      cal_ack_o <= (cnt == 16'(ACK_DELAY - 1));
    end
  end
endmodule : srac_cal_eng

/* File: srac_map.svh */
`ifndef SRAC_MAP_SVH
`define SRAC_MAP_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SRAC_REG_CMD 8'h00
`define SRAC_REG_RESP 8'h04
`define SRAC_REG_CTRL 8'h08
`define SRAC_REG_STAT 8'h0C
`define SRAC_REG_IRQ_STAT 8'h10
`define SRAC_REG_IRQ_CLR 8'h14
`define SRAC_REG_IRQ_EN 8'h18
`define SRAC_REG_SRE 8'h1C
`define SRAC_REG_ESE 8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define SRAC_CTRL_PULSE 0
`define SRAC_STAT_BUSY 0
`define SRAC_STAT_SRQ 1
`define SRAC_STAT_RESP 2
`define SRAC_STAT_PULSE 3
`define SRAC_STB_OLSB 0
`define SRAC_STB_CESB 2
`define SRAC_STB_MAV 4
`define SRAC_STB_ESB 5
`define SRAC_STB_MSS 6
`define SRAC_IRQ_DONE 0
`define SRAC_IRQ_CAL 1
`define SRAC_IRQ_REFUSED 2
`define SRAC_IRQ_SRQ 3
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SRAC_RST_BYTE 8'h00
`define SRAC_RST_IRQ 4'h0
`define SRAC_CLK_NS 5
`define SRAC_SRQ_PULSE_NS 1000
`endif

/* File: srac_pkg.sv */
package srac_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_CLEAR_STATUS = 4'h1,
    OP_STB_QUERY = 4'h2,
    OP_SRE_SET = 4'h3,
    OP_SRE_QUERY = 4'h4,
    OP_ESR_QUERY = 4'h5,
    OP_ESE_SET = 4'h6,
    OP_ESE_QUERY = 4'h7,
    OP_COMM_ERR_QUERY = 4'h8,
    OP_OVERLOAD_QUERY = 4'h9,
    OP_SELF_CAL = 4'hA
  } srac_op_t;
  typedef struct packed {
    logic [7:0] data;
    logic [6:0] rsvd;
    logic bitval;
    logic [2:0] idx;
    logic has_idx;
    srac_op_t op;
  } srac_cmd_t;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01,
    CAL_DONE = 2'b10
  } srac_cal_state_t;
endpackage : srac_pkg

/* File: srac_srq.sv */
`timescale 1ns/100ps
`include "srac_map.svh"
module srac_srq import srac_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic new_req_i,
  input wire logic clr_i,
  input wire logic pulse_mode_i,
  output logic srq_n_o
);
  // least pulse time rounds up to whole cycles
  localparam int PULSE_CYC_I = (`SRAC_SRQ_PULSE_NS + `SRAC_CLK_NS - 1) / `SRAC_CLK_NS;
  localparam logic [7:0] PULSE_CYC = PULSE_CYC_I[7:0];

  logic latched;
  logic [7:0] cnt;
  wire next_latched = ~pulse_mode_i & (new_req_i | (latched & ~clr_i)); // RULE11
  wire [7:0] next_cnt = (new_req_i & pulse_mode_i) ? PULSE_CYC :
                        (cnt != 8'h00) ? cnt - 8'h01 : 8'h00; // RULE11

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched <= 1'b0;
      cnt <= 8'h00;
      srq_n_o <= 1'b1;
    end else begin
      latched <= next_latched;
      cnt <= next_cnt;
      srq_n_o <= ~(next_latched | (next_cnt != 8'h00));
    end
  end

  chk_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    (new_req_i && pulse_mode_i) |=> (!srq_n_o && cnt == PULSE_CYC) ##199 !srq_n_o)
    else $error("pulse mode request shorter than one microsecond");
  chk_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    (new_req_i && !pulse_mode_i) ##1 (!clr_i && !pulse_mode_i)[*3] |=> !srq_n_o)
    else $error("latched request released without a clear");
  cov_pulse: cover property (@(posedge clk_i) disable iff (rst_i) new_req_i && pulse_mode_i);
endmodule : srac_srq

/* File: srac_top.sv */
// What this block does
// (RULE1) self-calibrate blocks further commands until finished
// (RULE2) host disconnects, zeroes output, checks error after; this block has no logic for it
// (RULE3) clear-status clears all three event registers
// (RULE4) status query returns whole byte or one bit
// (RULE5) full status query releases request line in latched mode; in pulse mode the pulse runs its full time
// (RULE6) indexed status query leaves request line alone
// (RULE7) request enable mask: whole or single bit
// (RULE8) standard event read clears returned bits
// (RULE9) event enable mask: whole or single bit
// (RULE10) comm error read clears returned bits
// (RULE11) request line latched, or pulsed one microsecond
// (RULE12) overload read clears returned bits
// (RULE13) enabled status bit rising raises new request
`timescale 1ns/100ps
`include "srac_map.svh"
module srac_top import srac_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] esr_evt_i,
  input wire logic [7:0] comm_error_evt_i,
  input wire logic [7:0] overload_evt_i,
  input wire logic cal_ack_i,
  output logic cal_run_o,
  output logic srq_n_o,
  output logic irq_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] esr;
  logic [7:0] comm_error_event_reg;
  logic [7:0] overload_event_reg;
  logic [7:0] sre;
  logic [7:0] ese;
  logic [7:0] resp;
  logic resp_valid;
  logic pulse_mode;
  logic [7:0] stb_prev;
  logic [3:0] irq_stat;
  logic [3:0] irq_en;
  logic busy;
  logic cal_done;

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  // ack low in the request term keeps one held access from being taken twice
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire rd_acc = req & ~wb_we_i;
  wire wr_acc = req & wb_we_i & wb_sel_i[0];
  wire cmd_wr = wr_acc & (wb_adr_i == `SRAC_REG_CMD);
  wire ctrl_wr = wr_acc & (wb_adr_i == `SRAC_REG_CTRL);
  wire iclr_wr = wr_acc & (wb_adr_i == `SRAC_REG_IRQ_CLR);
  wire ien_wr = wr_acc & (wb_adr_i == `SRAC_REG_IRQ_EN);
  wire resp_rd = rd_acc & (wb_adr_i == `SRAC_REG_RESP);
  srac_cmd_t cmd;
  assign cmd = srac_cmd_t'(wb_dat_i[23:0]);

  // commands are refused, not queued, while calibration runs
  wire cmd_go = cmd_wr & ~busy; // RULE1
  wire cmd_refused = cmd_wr & busy; // RULE1
  wire is_cls = cmd_go & (cmd.op == OP_CLEAR_STATUS);
  wire is_stbq = cmd_go & (cmd.op == OP_STB_QUERY);
  wire is_sre_set = cmd_go & (cmd.op == OP_SRE_SET);
  wire is_sre_q = cmd_go & (cmd.op == OP_SRE_QUERY);
  wire is_esr_q = cmd_go & (cmd.op == OP_ESR_QUERY);
  wire is_ese_set = cmd_go & (cmd.op == OP_ESE_SET);
  wire is_ese_q = cmd_go & (cmd.op == OP_ESE_QUERY);
  wire is_cerr_q = cmd_go & (cmd.op == OP_COMM_ERR_QUERY);
  wire is_ovld_q = cmd_go & (cmd.op == OP_OVERLOAD_QUERY);
  wire is_cal = cmd_go & (cmd.op == OP_SELF_CAL);
  wire is_query = is_stbq | is_sre_q | is_esr_q | is_ese_q | is_cerr_q | is_ovld_q;

  wire [7:0] idx_mask = 8'h01 << cmd.idx;
  wire [7:0] sel_mask = cmd.has_idx ? idx_mask : 8'hFF;

  // ----------------------------------------
  // status byte and request detection
  // ----------------------------------------
  logic [7:0] stb_low;
  always_comb begin
    stb_low = 8'h00;
    stb_low[`SRAC_STB_OLSB] = |overload_event_reg;
    stb_low[`SRAC_STB_CESB] = |comm_error_event_reg;
    stb_low[`SRAC_STB_MAV] = resp_valid;
    stb_low[`SRAC_STB_ESB] = |(esr & ese);
  end
  wire mss = |(stb_low & sre);
  wire [7:0] stb = stb_low | ({7'h00, mss} << `SRAC_STB_MSS);
  // only a fresh rising enabled bit asks again, so a held bit cannot re-fire after a clear
  wire new_req = |(stb_low & ~stb_prev & sre); // RULE13
  wire srq_clr = is_stbq & ~cmd.has_idx; // RULE5 RULE6

  // ----------------------------------------
  // query result
  // ----------------------------------------
  wire [7:0] q_src = is_stbq ? stb :
                     is_sre_q ? sre :
                     is_esr_q ? esr :
                     is_ese_q ? ese :
                     is_cerr_q ? comm_error_event_reg : overload_event_reg;
  wire [7:0] q_result = cmd.has_idx ? {7'h00, |(q_src & idx_mask)} : q_src; // RULE4

  // ----------------------------------------
  // event registers, clear on read, set wins
  // ----------------------------------------
  wire [7:0] esr_clr = (is_cls | is_esr_q) ? (is_cls ? 8'hFF : sel_mask) : 8'h00; // RULE3 RULE8
  wire [7:0] cerr_clr = (is_cls | is_cerr_q) ? (is_cls ? 8'hFF : sel_mask) : 8'h00; // RULE3 RULE10
  wire [7:0] ovld_clr = (is_cls | is_ovld_q) ? (is_cls ? 8'hFF : sel_mask) : 8'h00; // RULE3 RULE12
  logic [7:0] next_esr;
  logic [7:0] next_comm_error_event_reg;
  logic [7:0] next_overload_event_reg;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_evt
      assign next_esr[gi] = esr_evt_i[gi] | (esr[gi] & ~esr_clr[gi]); // RULE8
      assign next_comm_error_event_reg[gi] = comm_error_evt_i[gi] // RULE10
        | (comm_error_event_reg[gi] & ~cerr_clr[gi]);
      assign next_overload_event_reg[gi] = overload_evt_i[gi] // RULE12
        | (overload_event_reg[gi] & ~ovld_clr[gi]);
    end
  endgenerate

  // ----------------------------------------
  // enable masks
  // ----------------------------------------
  function automatic logic [7:0] upd_mask(input logic [7:0] cur, input srac_cmd_t c, input logic [7:0] m);
    upd_mask = c.has_idx ? ((cur & ~m) | (c.bitval ? m : 8'h00)) : c.data;
  endfunction : upd_mask
  wire [7:0] next_sre = is_sre_set ? upd_mask(sre, cmd, idx_mask) : sre; // RULE7
  wire [7:0] next_ese = is_ese_set ? upd_mask(ese, cmd, idx_mask) : ese; // RULE9
  wire next_resp_valid = is_query | (resp_valid & ~resp_rd);

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [3:0] irq_evt;
  always_comb begin
    irq_evt = 4'h0;
    irq_evt[`SRAC_IRQ_DONE] = cmd_go;
    irq_evt[`SRAC_IRQ_CAL] = cal_done;
    irq_evt[`SRAC_IRQ_REFUSED] = cmd_refused;
    irq_evt[`SRAC_IRQ_SRQ] = new_req;
  end
  wire [3:0] next_irq_stat = irq_evt | (irq_stat & ~(iclr_wr ? wb_dat_i[3:0] : 4'h0));
  wire [3:0] next_irq_en = ien_wr ? wb_dat_i[3:0] : irq_en;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [31:0] stat_word = {28'h0, pulse_mode, resp_valid, ~srq_n_o, busy};
  // unmapped offsets read as zero and are still answered, so a stray read cannot hang the bus
  wire [31:0] rd_data = (wb_adr_i == `SRAC_REG_RESP) ? {24'h0, resp} :
                        (wb_adr_i == `SRAC_REG_CTRL) ? {31'h0, pulse_mode} :
                        (wb_adr_i == `SRAC_REG_STAT) ? stat_word :
                        (wb_adr_i == `SRAC_REG_IRQ_STAT) ? {28'h0, irq_stat} :
                        (wb_adr_i == `SRAC_REG_IRQ_EN) ? {28'h0, irq_en} :
                        (wb_adr_i == `SRAC_REG_SRE) ? {24'h0, sre} :
                        (wb_adr_i == `SRAC_REG_ESE) ? {24'h0, ese} : 32'h0;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd_acc ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      esr <= `SRAC_RST_BYTE;
      comm_error_event_reg <= `SRAC_RST_BYTE;
      overload_event_reg <= `SRAC_RST_BYTE;
      sre <= `SRAC_RST_BYTE;
      ese <= `SRAC_RST_BYTE;
      stb_prev <= `SRAC_RST_BYTE;
    end else begin
      esr <= next_esr;
      comm_error_event_reg <= next_comm_error_event_reg;
      overload_event_reg <= next_overload_event_reg;
      sre <= next_sre;
      ese <= next_ese;
      stb_prev <= stb_low;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp <= `SRAC_RST_BYTE;
      resp_valid <= 1'b0;
      pulse_mode <= 1'b0;
      irq_stat <= `SRAC_RST_IRQ;
      irq_en <= `SRAC_RST_IRQ;
      irq_o <= 1'b0;
    end else begin
      if (is_query) resp <= q_result; // RULE4
      resp_valid <= next_resp_valid;
      if (ctrl_wr) pulse_mode <= wb_dat_i[`SRAC_CTRL_PULSE];
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      irq_o <= |(next_irq_stat & next_irq_en);
    end
  end

  // ----------------------------------------
  // calibration and request line
  // ----------------------------------------
  srac_cal u_cal (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(is_cal), // RULE1
    .cal_ack_i(cal_ack_i),
    .busy_o(busy),
    .run_o(cal_run_o),
    .done_o(cal_done)
  );

  srac_srq u_srq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .new_req_i(new_req),
    .clr_i(srq_clr),
    .pulse_mode_i(pulse_mode),
    .srq_n_o(srq_n_o)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_busy_refuse: assert property ((cmd_wr && busy) |=> $stable(sre) && $stable(ese)) // RULE1
    else $error("command executed during calibration");
  chk_cls_clears: assert property ((is_cls && esr_evt_i == 8'h00 && comm_error_evt_i == 8'h00 // RULE3
    && overload_evt_i == 8'h00) |=> (esr == 8'h00 && comm_error_event_reg == 8'h00
    && overload_event_reg == 8'h00))
    else $error("clear status left event bits");
  chk_bit_query: assert property ((is_stbq && cmd.has_idx) |=> resp == {7'h00, $past(stb[cmd.idx])}) // RULE4
    else $error("indexed status query returned wrong value");
  chk_full_release: assert property ((srq_clr && !new_req && !pulse_mode) |=> srq_n_o) // RULE5
    else $error("full status query did not release request line");
  chk_idx_keep: assert property ((is_stbq && cmd.has_idx && !new_req && !pulse_mode) // RULE6
    |=> $stable(srq_n_o))
    else $error("indexed status query changed request line");
  chk_sre_bit: assert property ((is_sre_set && cmd.has_idx) |=> // RULE7
    sre[$past(cmd.idx)] == $past(cmd.bitval) && ($past(sre[0]) == sre[0] || $past(cmd.idx) == 3'h0))
    else $error("service enable bit write failed");
  chk_esr_read: assert property ((is_esr_q && !cmd.has_idx && esr_evt_i == 8'h00) // RULE8
    |=> esr == 8'h00 && resp == $past(esr))
    else $error("standard event read did not clear");
  chk_ese_write: assert property ((is_ese_set && !cmd.has_idx) |=> ese == $past(cmd.data)) // RULE9
    else $error("event enable write failed");
  chk_comm_err_read: assert property ((is_cerr_q && cmd.has_idx && comm_error_evt_i == 8'h00) // RULE10
    |=> comm_error_event_reg == ($past(comm_error_event_reg) & ~$past(idx_mask)))
    else $error("comm error read cleared wrong bits");
  chk_overload_read: assert property ((is_ovld_q && !cmd.has_idx && overload_evt_i == 8'h00) // RULE12
    |=> overload_event_reg == 8'h00)
    else $error("overload read did not clear");
  chk_new_request: assert property ((new_req && !pulse_mode) |=> !srq_n_o ##1 (!srq_n_o || $past(srq_clr))) // RULE13
    else $error("enabled status bit did not raise request");
  chk_wb_ack: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");
  // clear checks demand quiet event inputs, since a fresh event may legally refill a cleared bit
  chk_stb_whole: assert property ((is_stbq && !cmd.has_idx) |=> // RULE4
    resp == {1'b0, $past(|(stb_low & sre)), $past(stb_low[5:0])})
    else $error("status byte query returned wrong value");
  chk_sre_write: assert property ((is_sre_set && !cmd.has_idx) |=> sre == $past(cmd.data)) // RULE7
    else $error("service enable write failed");
  chk_ese_bit: assert property ((is_ese_set && cmd.has_idx) |=> // RULE9
    ese[$past(cmd.idx)] == $past(cmd.bitval))
    else $error("event enable bit write failed");
  chk_esr_bit_read: assert property ((is_esr_q && cmd.has_idx && esr_evt_i == 8'h00) |=> // RULE8
    esr == ($past(esr) & ~$past(idx_mask)) && resp == {7'h00, $past(esr[cmd.idx])})
    else $error("indexed standard event read failed");
  chk_overload_bit: assert property ((is_ovld_q && cmd.has_idx && overload_evt_i == 8'h00) |=> // RULE12
    overload_event_reg == ($past(overload_event_reg) & ~$past(idx_mask)))
    else $error("indexed overload read cleared wrong bits");
  chk_comm_err_whole: assert property ((is_cerr_q && !cmd.has_idx && comm_error_evt_i == 8'h00) |=> // RULE10
    comm_error_event_reg == 8'h00 && resp == $past(comm_error_event_reg))
    else $error("comm error read did not clear");
  chk_refused_flag: assert property (cmd_refused |=> irq_stat[`SRAC_IRQ_REFUSED]) // RULE1
    else $error("refused command not flagged");
  chk_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside an answer");

  cov_cal_cmd: cover property (is_cal ##[1:20] cmd_refused);
  cov_srq_cycle: cover property (new_req ##[1:50] srq_clr);
  cov_esr_idx: cover property (is_esr_q && cmd.has_idx);
endmodule : srac_top

/* File: testbench.sv */
`timescale 1ns/100ps
`include "srac_map.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module testbench import srac_pkg::*;;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, esr_evt_i = 8'h00, comm_error_evt_i = 8'h00, overload_evt_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd;
  logic wb_ack_o, cal_ack_i, cal_run_o, srq_n_o, irq_o;
  int checks = 0, failures = 0, cycles = 0, n;
  logic [7:0] rr [3] = '{`SRAC_REG_CTRL, `SRAC_REG_IRQ_EN, 8'hFC};
  srac_op_t rop [3] = '{OP_ESR_QUERY, OP_COMM_ERR_QUERY, OP_OVERLOAD_QUERY};
  always #2.5 clk_i = ~clk_i;
  srac_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .esr_evt_i(esr_evt_i), .comm_error_evt_i(comm_error_evt_i),
    .overload_evt_i(overload_evt_i), .cal_ack_i(cal_ack_i), .cal_run_o(cal_run_o), .srq_n_o(srq_n_o),
    .irq_o(irq_o));
  srac_cal_eng #(.ACK_DELAY(60)) eng_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(cal_run_o),
    .cal_ack_o(cal_ack_i));
  task automatic end_of_test;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // whole run needs about 500 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i iff wb_ack_o === 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  // command write then response read; the read also drops response-valid
  task automatic cmd(input srac_op_t op, input logic hi, input logic [2:0] ix, input logic bv,
    input logic [7:0] dt, output logic [31:0] q);
    srac_cmd_t c;
    c = '{data: dt, rsvd: 7'h00, bitval: bv, idx: ix, has_idx: hi, op: op};
    wb(1'b1, `SRAC_REG_CMD, 32'(c), q);
    wb(1'b0, `SRAC_REG_RESP, 32'h0, q);
  endtask : cmd
  task automatic evt(input int k, input logic [7:0] v);
    @(posedge clk_i);
    esr_evt_i <= (k == 0) ? v : 8'h00;
    comm_error_evt_i <= (k == 1) ? v : 8'h00;
    overload_evt_i <= (k == 2) ? v : 8'h00;
    @(posedge clk_i);
    {esr_evt_i, comm_error_evt_i, overload_evt_i} <= 24'h000000;
  endtask : evt
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // ----------------------------------------
    // reset state and unmapped access
    // ----------------------------------------
    foreach (rr[i]) begin
      wb(1'b0, rr[i], 32'h0, rd);
      `CHK(rd, 32'h00000000)
    end
    wb(1'b1, 8'hFC, 32'hFFFFFFFF, rd);
    @(posedge clk_i);
    `CHK(wb_ack_o, 1'b0)
    `CHK(srq_n_o, 1'b1)
    done("reset");
    // ----------------------------------------
    // clear-on-read event registers, indexed then whole
    // ----------------------------------------
    foreach (rop[k]) begin
      evt(k, 8'h06);
      cmd(rop[k], 1'b1, 3'h1, 1'b0, 8'h00, rd);
      `CHK(rd[7:0], 8'h01)
      cmd(rop[k], 1'b0, 3'h0, 1'b0, 8'h00, rd);
      `CHK(rd[7:0], 8'h04)
      cmd(rop[k], 1'b0, 3'h0, 1'b0, 8'h00, rd);
      `CHK(rd[7:0], 8'h00)
    end
    done("event_reads");
    // ----------------------------------------
    // clear status empties all three event registers
    // ----------------------------------------
    for (int k = 0; k < 3; k++)
      evt(k, 8'h81);
    cmd(OP_CLEAR_STATUS, 1'b0, 3'h0, 1'b0, 8'h00, rd);
    foreach (rop[k]) begin
      cmd(rop[k], 1'b0, 3'h0, 1'b0, 8'h00, rd);
      `CHK(rd[7:0], 8'h00)
    end
    done("clear_status");
    // ----------------------------------------
    // enable masks: whole, bit set, bit clear
    // ----------------------------------------
    for (int m = 0; m < 2; m++) begin
      cmd(m ? OP_ESE_SET : OP_SRE_SET, 1'b0, 3'h0, 1'b0, 8'h30, rd);
      cmd(m ? OP_ESE_SET : OP_SRE_SET, 1'b1, 3'h0, 1'b1, 8'h00, rd);
      cmd(m ? OP_ESE_SET : OP_SRE_SET, 1'b1, 3'h4, 1'b0, 8'h00, rd);
      cmd(m ? OP_ESE_QUERY : OP_SRE_QUERY, 1'b0, 3'h0, 1'b0, 8'h00, rd);
      `CHK(rd[7:0], 8'h21)
      cmd(m ? OP_ESE_QUERY : OP_SRE_QUERY, 1'b1, 3'h5, 1'b0, 8'h00, rd);
      `CHK(rd[7:0], 8'h01)
      wb(1'b0, m ? `SRAC_REG_ESE : `SRAC_REG_SRE, 32'h0, rd);
      `CHK(rd[7:0], 8'h21)
    end
    done("enable_masks");
    // ----------------------------------------
    // latched request line and status byte query
    // ----------------------------------------
    cmd(OP_SRE_SET, 1'b0, 3'h0, 1'b0, 8'h01, rd);
    evt(2, 8'h08);
    repeat (3) @(posedge clk_i);
    `CHK(srq_n_o, 1'b0)
    cmd(OP_STB_QUERY, 1'b1, 3'h0, 1'b0, 8'h00, rd);
    `CHK(rd[7:0], 8'h01)
    `CHK(srq_n_o, 1'b0)
    cmd(OP_STB_QUERY, 1'b0, 3'h0, 1'b0, 8'h00, rd);
    `CHK(rd[7:0], 8'h41)
    `CHK(srq_n_o, 1'b1)
    cmd(OP_OVERLOAD_QUERY, 1'b0, 3'h0, 1'b0, 8'h00, rd);
    done("status_byte");
    // ----------------------------------------
    // pulse mode: line low for a fixed time, then free
    // ----------------------------------------
    wb(1'b1, `SRAC_REG_CTRL, 32'h1, rd);
    cmd(OP_SRE_SET, 1'b0, 3'h0, 1'b0, 8'h04, rd);
    evt(1, 8'h01);
    n = 0;
    while (srq_n_o !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (srq_n_o === 1'b0 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(n, 200)
    cmd(OP_COMM_ERR_QUERY, 1'b0, 3'h0, 1'b0, 8'h00, rd);
    wb(1'b1, `SRAC_REG_CTRL, 32'h0, rd);
    done("pulse_mode");
    // ----------------------------------------
    // self-calibration holds off commands; interrupt path
    // ----------------------------------------
    evt(0, 8'h01);
    wb(1'b1, `SRAC_REG_IRQ_CLR, 32'hF, rd);
    cmd(OP_SELF_CAL, 1'b0, 3'h0, 1'b0, 8'h00, rd);
    `CHK(cal_run_o, 1'b1)
    wb(1'b0, `SRAC_REG_STAT, 32'h0, rd);
    `CHK(rd[0], 1'b1)
    wb(1'b1, `SRAC_REG_IRQ_EN, 32'h2, rd);
    cmd(OP_ESR_QUERY, 1'b0, 3'h0, 1'b0, 8'h00, rd);
    wb(1'b0, `SRAC_REG_IRQ_STAT, 32'h0, rd);
    `CHK(rd[3:0], 4'h5)
    `CHK(irq_o, 1'b0)
    n = 0;
    while (cal_run_o === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    repeat (3) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    wb(1'b0, `SRAC_REG_STAT, 32'h0, rd);
    `CHK(rd[0], 1'b0)
    `CHK(cal_run_o, 1'b0)
    cmd(OP_ESR_QUERY, 1'b0, 3'h0, 1'b0, 8'h00, rd);
    `CHK(rd[7:0], 8'h01)
    wb(1'b1, `SRAC_REG_IRQ_CLR, 32'hF, rd);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    done("self_cal");
    end_of_test();
  end
endmodule : testbench
